// ==== hw/pwm_dt_defs.vh ====
// Purpose: constants for the pulse-width sync, divider and dead-time block
// Assumes: APB byte offsets within an 8-bit window
// Notes: times in ns, counts derived in the module
`ifndef PWM_DT_DEFS_VH
`define PWM_DT_DEFS_VH
`define A_CTRL 8'h00
`define A_PERIOD 8'h04
`define A_EVENT 8'h08
`define A_PHASE 8'h0C
`define A_ROUTE 8'h10
`define A_WINDOW 8'h14
`define A_THRESH 8'h18
`define A_ACC_A 8'h1C
`define A_ACC_B 8'h20
`define A_MONITOR 8'h24
`define A_IRQ_STAT 8'h28
`define A_IRQ_CLR 8'h2C
`define A_IRQ_EN 8'h30
`define C_RUN 0
`define C_DIV 4:1
`define C_MAN 5
`define C_FOL 8:6
`define EV_RISE 13:0
`define EV_FALL 29:16
`define RT_SEL1 1:0
`define RT_SEL2 3:2
`define RT_SEL3 5:4
`define W_BLANK 7:0
`define W_LEN 15:8
`define T_LO 7:0
`define T_HI 15:8
`define T_STEP 23:16
`define M_RES0 7:0
`define M_RES1 15:8
`define CLK_NS 12'h005
`define RES_NS 12'h004
`define ST_IDLE 3'h1
`define ST_BLANK 3'h2
`define ST_DET 3'h4
`define IRQ_DIV 0
`define IRQ_DT0 1
`define IRQ_DT1 2
`endif

// ==== hw/pwm_sync_irq_div_deadtime_adj.v ====
// Purpose: four chained pulse-width channels, divided period interrupt,
//          and rectifier dead-time optimizer with edge-adjust accumulators
// Assumes: pclk 200 MHz, APB slave, sense inputs asynchronous
// Notes: channel 0 timer drives rectifier_pwm_0, channel 1 rectifier_pwm_1
// Functional notes
// - Divider settings 1-15 map to table counts
// - Channels chain 0->1->2->3, offset set by the phase threshold
// - Follower only when enabled; select values 0,1,2
// - Same events give phase-shifted identical waveforms
// - Window opens after each rectifier falling edge
// - Window has programmable blanking and length
// - Conduction measured with 4 ns resolution
// - Measurement moves next cycle's turn-off edge
// - Signed accumulators reset zero, add step
// - Auto mode: threshold compare picks step
// - Manual mode: firmware writes, auto suspended
// - Period interrupt also triggers converter
// - Sync resets timer; threshold crossing emits sync
`timescale 1ns/1ps
`include "pwm_dt_defs.vh"
`default_nettype none

module pwm_sync_irq_div_deadtime_adj (
    input wire pclk, // 200 MHz clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg pready, // APB ready
    output reg [31:0] prdata, // APB read data
    output reg pslverr, // APB error on unmapped address
    input wire conduction_sense_0, // Body diode sense, rectifier 0
    input wire conduction_sense_1, // Body diode sense, rectifier 1
    output reg [3:0] pwm_out, // Channel outputs
    output reg [3:0] sync_out, // Sync pulses per channel
    output reg rectifier_pwm_0, // Rectifier gate 0
    output reg rectifier_pwm_1, // Rectifier gate 1
    output reg adc_trigger, // Converter trigger pulse
    output reg irq // Level interrupt
);

    // Divider table: setting to divide count
    function [7:0] div_count;
        input [3:0] s;
        begin
            case (s)
                4'h1: div_count = 8'h00;
                4'h2: div_count = 8'h01;
                4'h3: div_count = 8'h03;
                4'h4: div_count = 8'h07;
                4'h5: div_count = 8'h0F;
                4'h6: div_count = 8'h1F;
                4'h7: div_count = 8'h2F;
                4'h8: div_count = 8'h3F;
                4'h9: div_count = 8'h4F;
                4'hA: div_count = 8'h5F;
                4'hB: div_count = 8'h7F;
                4'hC: div_count = 8'h9F;
                4'hD: div_count = 8'hBF;
                4'hE: div_count = 8'hDF;
                default: div_count = 8'hFF;
            endcase
        end
    endfunction

    // Sync source pick; value 3 selects nothing
    function pick_sync;
        input [1:0] sel;
        input [3:0] src;
        begin
            if (sel == 2'h3) begin
                pick_sync = 1'b0;
            end else begin
                pick_sync = src[sel];
            end
        end
    endfunction

    // Accumulator step from measured conduction
    function [15:0] step_of;
        input [7:0] m;
        input [23:0] th;
        begin
            if (m > th[`T_HI]) begin
                step_of = {8'h00, th[`T_STEP]};
            end else if (m < th[`T_LO]) begin
                step_of = 16'h0000 - {8'h00, th[`T_STEP]};
            end else begin
                step_of = 16'h0000;
            end
        end
    endfunction

    // Window result in 4 ns units; clipped so a long window cannot wrap
    function [7:0] res_of;
        input [11:0] m;
        input s;
        reg [11:0] q;
        begin
            q = (m + (s ? `CLK_NS : 12'h000)) / `RES_NS;
            res_of = (q > 12'h0FF) ? 8'hFF : q[7:0];
        end
    endfunction

    reg [8:0] ctrl_q;
    reg [13:0] period_q;
    reg [29:0] event_q;
    reg [13:0] phase_trigger_threshold;
    reg [5:0] pwm_sync_routing;
    reg [15:0] window_q;
    reg [23:0] thresh_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;
    reg [13:0] cnt_q [0:3];
    reg [7:0] div_cnt_q;
    reg [1:0] rect_p_q;
    reg [2:0] st_q [0:1];
    reg [7:0] tcnt_q [0:1];
    reg [11:0] meas_q [0:1];
    reg [7:0] res_q [0:1];
    reg [15:0] acc_q [0:1];
    reg [1:0] done_q;
    reg [1:0] sense_m_q;
    reg [1:0] sense_q;
    reg [31:0] rd_mux;
    reg map_ok;
    integer i;
    integer j;

    wire run = ctrl_q[`C_RUN];
    wire manual = ctrl_q[`C_MAN];
    wire [3:0] follower = {ctrl_q[`C_FOL], 1'b0};
    wire [1:0] rect_now = {rectifier_pwm_1, rectifier_pwm_0};
    wire wr_en = psel & penable & pwrite & pready;
    wire [3:0] sync_in;
    wire period_end;
    wire [13:0] fall_adj0;
    wire [13:0] fall_adj1;

    // Chain routing from the select fields
    assign sync_in[0] = 1'b0;
    assign sync_in[1] = pick_sync(pwm_sync_routing[`RT_SEL1], sync_out);
    assign sync_in[2] = pick_sync(pwm_sync_routing[`RT_SEL2], sync_out);
    assign sync_in[3] = pick_sync(pwm_sync_routing[`RT_SEL3], sync_out);
    assign period_end = run & (cnt_q[0] == period_q - 14'h0001);
    // Turn-off edge moved by the accumulator
    assign fall_adj0 = event_q[`EV_FALL] + acc_q[0][13:0];
    assign fall_adj1 = event_q[`EV_FALL] + acc_q[1][13:0];

    // Sense inputs come from another chip: two flops first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_m_q <= 2'h0;
            sense_q <= 2'h0;
        end else begin
            sense_m_q <= {conduction_sense_1, conduction_sense_0};
            sense_q <= sense_m_q;
        end
    end

    // Read mux and address map
    always @* begin
        rd_mux = 32'h0000_0000;
        map_ok = 1'b1;
        case (paddr)
            `A_CTRL: rd_mux = {23'h000000, ctrl_q};
            `A_PERIOD: rd_mux = {18'h00000, period_q};
            `A_EVENT: rd_mux = {2'h0, event_q};
            `A_PHASE: rd_mux = {18'h00000, phase_trigger_threshold};
            `A_ROUTE: rd_mux = {26'h0000000, pwm_sync_routing};
            `A_WINDOW: rd_mux = {16'h0000, window_q};
            `A_THRESH: rd_mux = {8'h00, thresh_q};
            `A_ACC_A: rd_mux = {16'h0000, acc_q[0]};
            `A_ACC_B: rd_mux = {16'h0000, acc_q[1]};
            `A_MONITOR: rd_mux = {16'h0000, res_q[1], res_q[0]};
            `A_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_q};
            `A_IRQ_CLR: rd_mux = 32'h0000_0000;
            `A_IRQ_EN: rd_mux = {29'h00000000, irq_en_q};
            default: map_ok = 1'b0;
        endcase
    end

    // APB slave: ready registered in setup, so no wait state and every output is a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~map_ok;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 9'h000;
            period_q <= 14'h0000;
            event_q <= 30'h00000000;
            phase_trigger_threshold <= 14'h0000;
            pwm_sync_routing <= 6'h3F;
            window_q <= 16'h0000;
            thresh_q <= 24'h000000;
            irq_en_q <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                `A_CTRL: ctrl_q <= pwdata[8:0];
                `A_PERIOD: period_q <= pwdata[13:0];
                `A_EVENT: event_q <= pwdata[29:0];
                `A_PHASE: phase_trigger_threshold <= pwdata[13:0];
                `A_ROUTE: pwm_sync_routing <= pwdata[5:0];
                `A_WINDOW: window_q <= pwdata[15:0];
                `A_THRESH: thresh_q <= pwdata[23:0];
                `A_IRQ_EN: irq_en_q <= pwdata[2:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Ramp timers; followers restart on their chosen sync
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 4; i = i + 1) begin
                cnt_q[i] <= 14'h0000;
            end
            sync_out <= 4'h0;
            pwm_out <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (!run) begin
                    cnt_q[i] <= 14'h0000;
                end else if (follower[i] & sync_in[i]) begin
                    cnt_q[i] <= 14'h0000;
                end else if (cnt_q[i] >= period_q - 14'h0001) begin
                    cnt_q[i] <= 14'h0000;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 14'h0001;
                end
                // Crossing the phase threshold emits sync once
                sync_out[i] <= run & (cnt_q[i] == phase_trigger_threshold);
                // Shared events: copies differ only by phase
                pwm_out[i] <= run & (cnt_q[i] >= event_q[`EV_RISE]) &
                    (cnt_q[i] < event_q[`EV_FALL]);
            end
        end
    end

    // Rectifier gates from timers 0 and 1 with moved turn-off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rectifier_pwm_0 <= 1'b0;
            rectifier_pwm_1 <= 1'b0;
            rect_p_q <= 2'h0;
        end else begin
            rectifier_pwm_0 <= run & (cnt_q[0] >= event_q[`EV_RISE]) &
                (cnt_q[0] < fall_adj0);
            rectifier_pwm_1 <= run & (cnt_q[1] >= event_q[`EV_RISE]) &
                (cnt_q[1] < fall_adj1);
            rect_p_q <= rect_now;
        end
    end

    // Period divider; setting 0 gives no interrupt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 8'h00;
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= 1'b0;
            if (!run || ctrl_q[`C_DIV] == 4'h0) begin
                div_cnt_q <= 8'h00;
            end else if (period_end) begin
                if (div_cnt_q == div_count(ctrl_q[`C_DIV])) begin
                    div_cnt_q <= 8'h00;
                    adc_trigger <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 8'h01;
                end
            end
        end
    end

    // Detection window, measurement and accumulators per rectifier
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (j = 0; j < 2; j = j + 1) begin
                st_q[j] <= `ST_IDLE;
                tcnt_q[j] <= 8'h00;
                meas_q[j] <= 12'h000;
                res_q[j] <= 8'h00;
                acc_q[j] <= 16'h0000;
            end
            done_q <= 2'h0;
        end else begin
            done_q <= 2'h0;
            for (j = 0; j < 2; j = j + 1) begin
                case (st_q[j])
                    `ST_IDLE: begin
                        // Window opens on the gate's falling edge
                        if (rect_p_q[j] & ~rect_now[j]) begin
                            tcnt_q[j] <= 8'h00;
                            meas_q[j] <= 12'h000;
                            st_q[j] <= (window_q[`W_BLANK] == 8'h00) ?
                                `ST_DET : `ST_BLANK;
                        end
                    end
                    `ST_BLANK: begin
                        // Sense ignored during blanking
                        if (tcnt_q[j] + 8'h01 >= window_q[`W_BLANK]) begin
                            tcnt_q[j] <= 8'h00;
                            st_q[j] <= `ST_DET;
                        end else begin
                            tcnt_q[j] <= tcnt_q[j] + 8'h01;
                        end
                    end
                    `ST_DET: begin
                        // Each sensed cycle adds 5 ns, read in 4 ns units
                        meas_q[j] <= meas_q[j] + (sense_q[j] ? `CLK_NS : 12'h000);
                        tcnt_q[j] <= tcnt_q[j] + 8'h01;
                        if (tcnt_q[j] + 8'h01 >= window_q[`W_LEN]) begin
                            st_q[j] <= `ST_IDLE;
                            res_q[j] <= res_of(meas_q[j], sense_q[j]);
                            done_q[j] <= 1'b1;
                            if (!manual) begin
                                acc_q[j] <= acc_q[j] +
                                    step_of(res_of(meas_q[j], sense_q[j]), thresh_q);
                            end
                        end
                    end
                    default: st_q[j] <= `ST_IDLE;
                endcase
            end
            // Firmware owns the accumulators only in manual mode
            if (wr_en && manual && paddr == `A_ACC_A) begin
                acc_q[0] <= pwdata[15:0];
            end
            if (wr_en && manual && paddr == `A_ACC_B) begin
                acc_q[1] <= pwdata[15:0];
            end
        end
    end

    // Sticky status: a new event beats a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q &
                ~((wr_en && paddr == `A_IRQ_CLR) ? pwdata[2:0] : 3'h0)) |
                {done_q, adc_trigger};
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

endmodule // pwm_sync_irq_div_deadtime_adj
`default_nettype wire

// ==== bench/pwm_dt_props.sv ====
// Purpose: bus and output timing checks for the pwm block
// Assumes: bound to the design top, one clock domain
// Notes: watches design outputs except rectifier_pwm_1 and irq, and the select, enable and reset inputs
`timescale 1ns/1ps
`default_nettype none
module pwm_dt_checker (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [31:0] prdata, // Read data
    input wire logic [3:0] pwm_out, // Channel outputs
    input wire logic [3:0] sync_out, // Sync pulses
    input wire logic rectifier_pwm_0, // Rectifier gate
    input wire logic adc_trigger // Divided period pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answer comes one cycle after setup and stands one cycle
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without ready or with data");
    chk_rdata_held: assert property (pready ##1 !psel |-> $stable(prdata))
        else $error("prdata changed without setup");
    chk_trig_single: assert property (adc_trigger |=> !adc_trigger)
        else $error("converter trigger longer than a cycle");
    chk_sync_single: assert property (|sync_out |=> (sync_out & $past(sync_out)) == 4'h0)
        else $error("sync pulse longer than a cycle");
    chk_rect_rise_aligned: assert property ($rose(pwm_out[0]) |-> $rose(rectifier_pwm_0))
        else $error("rectifier rise off its timer");
    chk_trig_spacing: assert property (adc_trigger |=> !adc_trigger [*1])
        else $error("trigger repeated at once");
    // Main scenarios seen
    cover property (adc_trigger);
    cover property (sync_out[3]);
    cover property (pslverr);
endmodule // pwm_dt_checker
bind pwm_sync_irq_div_deadtime_adj pwm_dt_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pwm_out(pwm_out), .sync_out(sync_out), .rectifier_pwm_0(rectifier_pwm_0),
    .adc_trigger(adc_trigger));
`default_nettype wire

// ==== bench/rect_driver_model.sv ====
// Purpose: behavioural rectifier gate driver returning conduction sense
// Assumes: the body diode conducts after each gate turn-off
// Notes: late mode puts conduction outside the detect window
`timescale 1ns/1ps
`default_nettype none
module rect_driver_model (
    input wire logic pclk, // Clock
    input wire logic rectifier_pwm_0, // Gate 0
    input wire logic rectifier_pwm_1, // Gate 1
    input wire logic late, // Conduct late
    output logic conduction_sense_0, // Sense 0
    output logic conduction_sense_1 // Sense 1
);
    logic [1:0] gate;
    logic [1:0] sense;
    assign gate = {rectifier_pwm_1, rectifier_pwm_0};
    assign conduction_sense_0 = sense[0];
    assign conduction_sense_1 = sense[1];
    for (genvar k = 0; k < 2; k++) begin : g_ch
        logic prev_q;
        int t_q;
        // Time since turn-off; the sense line is driven low when not conducting
        always @(posedge pclk) begin
            prev_q <= gate[k];
            if (prev_q && !gate[k]) begin
                t_q <= 1;
            end else if (t_q != 0 && t_q < 40) begin
                t_q <= t_q + 1;
            end else begin
                t_q <= 0;
            end
        end
        assign sense[k] = late ? (t_q >= 30 && t_q < 38) : (t_q >= 1 && t_q < 20);
    end
endmodule // rect_driver_model
`default_nettype wire

// ==== bench/tb_pwm_sync_irq_div_deadtime_adj.sv ====
// Purpose: self-checking bench for the pwm sync, divider and dead-time block
// Assumes: offsets and fields from the shared defines header
// Notes: short periods keep the divider sweep well inside the timeout
`timescale 1ns/1ps
`include "pwm_dt_defs.vh"
`default_nettype none
module tb_pwm_sync_irq_div_deadtime_adj;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, late = 0, errq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic pready, pslverr, sense0, sense1, rect0, rect1, adc_trigger, irq;
    logic [3:0] pwm_out, sync_out;
    int errors = 0, num_checks = 0, cyc = 0;
    logic [7:0] dcnt [15] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h2F, 8'h3F,
        8'h4F, 8'h5F, 8'h7F, 8'h9F, 8'hBF, 8'hDF, 8'hFF};
    pwm_sync_irq_div_deadtime_adj u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .conduction_sense_0(sense0),
        .conduction_sense_1(sense1), .pwm_out(pwm_out), .sync_out(sync_out),
        .rectifier_pwm_0(rect0), .rectifier_pwm_1(rect1), .adc_trigger(adc_trigger), .irq(irq));
    rect_driver_model u_drv (.pclk(pclk), .rectifier_pwm_0(rect0), .rectifier_pwm_1(rect1),
        .late(late), .conduction_sense_0(sense0), .conduction_sense_1(sense1));
    // 200 MHz clock
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // Watchdog: a stuck wait would otherwise never end the run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    // One transfer; the idle cycle after it keeps drivers from double assignment
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        errq = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    function automatic logic sig(input int i);
        logic [4:0] v;
        v = {rect0, pwm_out};
        return v[i];
    endfunction
    task automatic rise(input int i);
        do @(posedge pclk); while (sig(i) !== 1'h0);
        do @(posedge pclk); while (sig(i) !== 1'h1);
    endtask
    task automatic width(input int i, output int w);
        rise(i);
        w = 0;
        while (sig(i) === 1'h1) begin
            @(posedge pclk);
            w++;
        end
    endtask
    task automatic trig;
        do @(posedge pclk); while (adc_trigger !== 1'h1);
    endtask
    task automatic t_reset;
        apb(1'h0, `A_ROUTE, 32'h0);
        chk("route reset", 32'h3F, rd);
        apb(1'h0, `A_ACC_A, 32'h0);
        chk("acc a reset", 32'h0, rd);
        apb(1'h0, `A_ACC_B, 32'h0);
        chk("acc b reset", 32'h0, rd);
        apb(1'h0, 8'hFC, 32'h0);
        chk("unmapped error", 32'h1, errq);
        $display("reset test done");
    endtask
    task automatic t_divider;
        int t0;
        apb(1'h1, `A_PERIOD, 32'h4);
        for (int s = 1; s <= 15; s++) begin
            apb(1'h1, `A_CTRL, 32'(s * 2 + 1));
            trig();
            trig();
            t0 = cyc;
            trig();
            chk("divider period", (dcnt[s - 1] + 1) * 4, cyc - t0);
        end
        apb(1'h1, `A_CTRL, 32'h3);
        trig();
        apb(1'h1, `A_CTRL, 32'h0);
        apb(1'h0, `A_IRQ_STAT, 32'h0);
        chk("period status", 32'h1, rd & 32'h1);
        chk("irq masked", 32'h0, irq);
        apb(1'h1, `A_IRQ_EN, 32'h1);
        @(posedge pclk);
        chk("irq raised", 32'h1, irq);
        apb(1'h1, `A_IRQ_CLR, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, irq);
        $display("divider test done");
    endtask
    task automatic t_sync;
        int n;
        apb(1'h1, `A_PERIOD, 32'h28);
        apb(1'h1, `A_EVENT, 32'h000A_0000);
        apb(1'h1, `A_PHASE, 32'h14);
        apb(1'h1, `A_ROUTE, 32'h24);
        apb(1'h1, `A_CTRL, 32'h1);
        rise(0);
        chk("unsynced outputs", 32'hF, pwm_out);
        // Sync pulse trails the output rise by the phase threshold
        n = 0;
        while (sync_out[0] !== 1'h1) begin
            @(posedge pclk);
            n++;
        end
        chk("sync position", 32'h14, n);
        apb(1'h1, `A_CTRL, 32'h1C1);
        repeat (200) @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            rise(i);
            n = 0;
            while (sig(i + 1) !== 1'h1) begin
                @(posedge pclk);
                n++;
            end
            chk("chain lag", 32'h16, n);
            width(i + 1, n);
            chk("follower width", 32'hA, n);
        end
        apb(1'h1, `A_CTRL, 32'h0);
        $display("sync test done");
    endtask
    task automatic t_deadtime;
        int w0, w1;
        apb(1'h1, `A_PERIOD, 32'h40);
        apb(1'h1, `A_EVENT, 32'h0014_0000);
        apb(1'h1, `A_WINDOW, 32'h0802);
        apb(1'h1, `A_THRESH, 32'h0001_0804);
        apb(1'h1, `A_CTRL, 32'h1);
        width(4, w0);
        width(4, w1);
        chk("later turn-off", w0 + 1, w1);
        apb(1'h0, `A_MONITOR, 32'h0);
        chk("monitor long", 32'h0A0A, rd & 32'hFFFF);
        apb(1'h0, `A_IRQ_STAT, 32'h0);
        chk("window done", 32'h6, rd & 32'h6);
        late <= 1'h1;
        repeat (130) @(posedge pclk);
        width(4, w0);
        width(4, w1);
        chk("earlier turn-off", w0 - 1, w1);
        apb(1'h0, `A_MONITOR, 32'h0);
        chk("monitor outside", 32'h0, rd & 32'hFFFF);
        apb(1'h1, `A_CTRL, 32'h21);
        apb(1'h1, `A_ACC_A, 32'h5);
        width(4, w0);
        width(4, w0);
        chk("manual turn-off", 32'h19, w0);
        apb(1'h0, `A_ACC_A, 32'h0);
        chk("acc held", 32'h5, rd & 32'hFFFF);
        $display("deadtime test done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_divider();
        t_sync();
        t_deadtime();
        summarize();
    end
endmodule // tb_pwm_sync_irq_div_deadtime_adj
`default_nettype wire
